// ---- cpu_exception_sequencer.sv ----
// exception sequencer: reset entry, interrupts, traps, illegal and privileged opcodes
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "cpu_exception_sequencer_cfg.svh"
module cpu_exception_sequencer (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [2:0] ipl_i,
   input wire logic decode_i,
   input wire logic done_i,
   input wire logic [15:0] opword_i,
   input wire logic [23:0] pc_i,
   input wire logic [23:0] next_pc_i,
   input wire logic illegal_i,
   input wire logic ovf_i,
   input wire logic bounds_i,
   input wire logic divzero_i,
   input wire logic mem_ack_i,
   input wire logic mem_berr_i,
   input wire logic mem_avec_i,
   input wire logic [15:0] mem_rdata_i,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [2:0] mem_fc_o,
   output logic [23:0] mem_addr_o,
   output logic [15:0] mem_wdata_o,
   output logic go_o,
   output logic resume_o,
   output logic [23:0] pc_o,
   output logic busy_o,
   output logic reset_out_o
);
   // ***********************************************
   // helper functions
   // ***********************************************
   // byte-lane merge for bus writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // vector number to byte address, handler is two words
   function automatic logic [23:0] vec_addr(input logic [7:0] v);
      return {14'h0, v, 2'h0};
   endfunction

   // privileged opcodes
   function automatic logic is_priv(input logic [15:0] op);
      return op == `OP_HALT || op == `OP_SW_RESET || op == `OP_EXC_RET
         || (op & `MASK_MOVE_SR) == `OP_MOVE_SR || op == `OP_ANDI_SR
         || op == `OP_EORI_SR || op == `OP_ORI_SR
         || (op & `MASK_LOW4) == `OP_USP_MOVE;
   endfunction

   // trap raised by a completed instruction: {hit, vector}
   function automatic logic [8:0] trap_of(input logic [15:0] op, input logic ov,
                                          input logic bd, input logic dz);
      logic [8:0] r;
      r = 9'h000;
      if ((op & `MASK_LOW4) == `OP_TRAP) begin
         r = {1'b1, `VEC_TRAP_BASE + {4'h0, op[3:0]}};
      end else if (op == `OP_OVF_TRAP && ov) begin
         r = {1'b1, `VEC_OVF_TRAP};
      end else if ((op & `MASK_EA_OP) == `OP_BOUNDS && bd) begin
         r = {1'b1, `VEC_BOUNDS};
      end else if (((op & `MASK_EA_OP) == `OP_UDIV || (op & `MASK_EA_OP) == `OP_SDIV)
                   && dz) begin
         r = {1'b1, `VEC_ZERO_DIV};
      end
      return r;
   endfunction

   // ***********************************************
   // state
   // ***********************************************
   cpu_exception_sequencer_pkg::seq_state_t state_q;
   logic [15:0] sr_q;
   logic [15:0] sr_copy_q;
   logic [23:0] ssp_q;
   logic [23:0] saved_pc_q;
   logic [7:0] vec_q;
   logic [1:0] idx_q;
   logic [7:0] rst_cnt_q;
   logic [2:0] ipl_s1_q, ipl_s2_q, ipl_s3_q;
   logic [2:0] lvl_q;
   logic [2:0] lvl_prev_q;
   logic nmi_q;
   logic [2:0] mask;
   logic supervisor;
   logic mem_done;
   logic int_take;
   logic [2:0] take_lvl;
   logic int_fire;
   logic wb_wr;
   logic [8:0] trap;
   logic [15:0] op;

   assign mask = sr_q[`SR_MASK_HI:`SR_MASK_LO];
   assign supervisor = sr_q[`SR_S];
   assign mem_done = mem_req_o && (mem_ack_i || mem_berr_i);
   assign op = opword_i;
   assign trap = trap_of(opword_i, ovf_i, bounds_i, divzero_i);
   // a rise to seven is taken even when the mask is seven
   assign int_take = nmi_q || (lvl_q != 3'h0 && lvl_q > mask);
   assign take_lvl = nmi_q ? `LEVEL_TOP : lvl_q;
   assign int_fire = state_q == cpu_exception_sequencer_pkg::ST_IDLE && decode_i
      && !done_i && int_take;
   assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

   // ***********************************************
   // request level input
   // ***********************************************
   // three flops; the level moves only when the last two agree
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ipl_s1_q <= 3'h0;
         ipl_s2_q <= 3'h0;
         ipl_s3_q <= 3'h0;
         lvl_q <= 3'h0;
         lvl_prev_q <= 3'h0;
      end else begin
         ipl_s1_q <= ipl_i;
         ipl_s2_q <= ipl_s1_q;
         ipl_s3_q <= ipl_s2_q;
         if (ipl_s2_q == ipl_s3_q) begin
            lvl_q <= ipl_s3_q;
         end
         lvl_prev_q <= lvl_q;
      end
   end

   // edge flag for level seven; a new rise beats the clear
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         nmi_q <= 1'b0;
      end else if (lvl_q == `LEVEL_TOP && lvl_prev_q != `LEVEL_TOP) begin
         nmi_q <= 1'b1;
      end else if (int_fire && take_lvl == `LEVEL_TOP) begin
         nmi_q <= 1'b0;
      end
   end

   // ***********************************************
   // sequencer
   // ***********************************************
   // one block owns status, stack pointer and the memory port so that a
   // hardware update and a bus write never fight over the same flop
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_q <= cpu_exception_sequencer_pkg::ST_BOOT;
         sr_q <= `SR_RESET;
         sr_copy_q <= 16'h0000;
         ssp_q <= 24'h000000;
         saved_pc_q <= 24'h000000;
         vec_q <= `VEC_RESET;
         idx_q <= 2'h0;
         rst_cnt_q <= 8'h00;
         mem_req_o <= 1'b1;
         mem_we_o <= 1'b0;
         mem_fc_o <= `FC_SUP_PROG;
         mem_addr_o <= vec_addr(`VEC_RESET);
         mem_wdata_o <= 16'h0000;
         go_o <= 1'b0;
         resume_o <= 1'b0;
         pc_o <= 24'h000000;
         busy_o <= 1'b1;
         reset_out_o <= 1'b0;
      end else begin
         go_o <= 1'b0;
         resume_o <= 1'b0;
         // software may rewrite status and stack pointer; hardware below wins
         if (wb_wr && wb_adr_i == `REG_STATUS_WORD) begin
            sr_q <= 16'(merge({16'h0000, sr_q}, wb_dat_i, wb_sel_i));
         end
         if (wb_wr && wb_adr_i == `REG_SSP) begin
            ssp_q <= 24'(merge({8'h00, ssp_q}, wb_dat_i, wb_sel_i));
         end
         unique case (state_q)
            cpu_exception_sequencer_pkg::ST_BOOT: begin
               // four reads, nothing stacked
               if (mem_done) begin
                  unique case (idx_q)
                     2'h0: ssp_q[23:16] <= mem_rdata_i[7:0];
                     2'h1: ssp_q[15:0] <= mem_rdata_i;
                     2'h2: pc_o[23:16] <= mem_rdata_i[7:0];
                     2'h3: pc_o[15:0] <= mem_rdata_i;
                  endcase
                  idx_q <= idx_q + 2'h1;
                  mem_addr_o <= mem_addr_o + 24'h000002;
                  if (idx_q == 2'h3) begin
                     mem_req_o <= 1'b0;
                     resume_o <= 1'b1;
                     busy_o <= 1'b0;
                     state_q <= cpu_exception_sequencer_pkg::ST_IDLE;
                  end
               end
            end
            cpu_exception_sequencer_pkg::ST_IDLE: begin
               if (done_i) begin
                  // execution-time traps resume after the trapping word
                  if (trap[8]) begin
                     sr_copy_q <= sr_q;
                     sr_q[`SR_S] <= 1'b1;
                     sr_q[`SR_T] <= 1'b0;
                     vec_q <= trap[7:0];
                     saved_pc_q <= next_pc_i;
                     mem_req_o <= 1'b1;
                     mem_we_o <= 1'b1;
                     mem_fc_o <= `FC_SUP_DATA;
                     mem_addr_o <= ssp_q - 24'h000002;
                     mem_wdata_o <= next_pc_i[15:0];
                     ssp_q <= ssp_q - 24'h000002;
                     idx_q <= 2'h0;
                     busy_o <= 1'b1;
                     state_q <= cpu_exception_sequencer_pkg::ST_PUSH;
                  end
               end else if (decode_i) begin
                  // interrupts first, then illegal and privilege checks
                  if (int_take) begin
                     sr_copy_q <= sr_q;
                     sr_q[`SR_S] <= 1'b1;
                     sr_q[`SR_T] <= 1'b0;
                     sr_q[`SR_MASK_HI:`SR_MASK_LO] <= take_lvl;
                     saved_pc_q <= pc_i;
                     mem_req_o <= 1'b1;
                     mem_we_o <= 1'b0;
                     mem_fc_o <= `FC_IACK;
                     mem_addr_o <= {20'hFFFFF, take_lvl, 1'b1};
                     busy_o <= 1'b1;
                     state_q <= cpu_exception_sequencer_pkg::ST_IACK;
                  end else if (illegal_i || op == `OP_ILL_A || op == `OP_ILL_B
                               || op == `OP_ILL_C || op[15:12] == `LINE_A
                               || op[15:12] == `LINE_F
                               || (!supervisor && is_priv(op))) begin
                     sr_copy_q <= sr_q;
                     sr_q[`SR_S] <= 1'b1;
                     sr_q[`SR_T] <= 1'b0;
                     if (op[15:12] == `LINE_A) begin
                        vec_q <= `VEC_LINE_A;
                     end else if (op[15:12] == `LINE_F) begin
                        vec_q <= `VEC_LINE_F;
                     end else if (illegal_i || op == `OP_ILL_A || op == `OP_ILL_B
                                  || op == `OP_ILL_C) begin
                        vec_q <= `VEC_ILLEGAL;
                     end else begin
                        vec_q <= `VEC_PRIV;
                     end
                     saved_pc_q <= pc_i;
                     mem_req_o <= 1'b1;
                     mem_we_o <= 1'b1;
                     mem_fc_o <= `FC_SUP_DATA;
                     mem_addr_o <= ssp_q - 24'h000002;
                     mem_wdata_o <= pc_i[15:0];
                     ssp_q <= ssp_q - 24'h000002;
                     idx_q <= 2'h0;
                     busy_o <= 1'b1;
                     state_q <= cpu_exception_sequencer_pkg::ST_PUSH;
                  end else if (op == `OP_SW_RESET) begin
                     // pulse the line only; the vector stays untouched
                     reset_out_o <= 1'b1;
                     rst_cnt_q <= 8'(`RST_OUT_CYC - 1);
                     busy_o <= 1'b1;
                     state_q <= cpu_exception_sequencer_pkg::ST_RSTOUT;
                  end else begin
                     go_o <= 1'b1;
                  end
               end
            end
            cpu_exception_sequencer_pkg::ST_IACK: begin
               // bus error wins over autovector, which wins over device data
               if (mem_done) begin
                  if (mem_berr_i) begin
                     vec_q <= `VEC_SPURIOUS;
                  end else if (mem_avec_i) begin
                     vec_q <= `VEC_AUTO_BASE + {5'h00, mem_addr_o[3:1]};
                  end else begin
                     vec_q <= mem_rdata_i[7:0];
                  end
                  mem_we_o <= 1'b1;
                  mem_fc_o <= `FC_SUP_DATA;
                  mem_addr_o <= ssp_q - 24'h000002;
                  mem_wdata_o <= saved_pc_q[15:0];
                  ssp_q <= ssp_q - 24'h000002;
                  idx_q <= 2'h0;
                  state_q <= cpu_exception_sequencer_pkg::ST_PUSH;
               end
            end
            cpu_exception_sequencer_pkg::ST_PUSH: begin
               // counter low, counter high, then the status copy
               if (mem_done) begin
                  idx_q <= idx_q + 2'h1;
                  if (idx_q == 2'h2) begin
                     mem_we_o <= 1'b0;
                     mem_addr_o <= vec_addr(vec_q);
                     idx_q <= 2'h0;
                     state_q <= cpu_exception_sequencer_pkg::ST_VEC;
                  end else begin
                     mem_addr_o <= ssp_q - 24'h000002;
                     ssp_q <= ssp_q - 24'h000002;
                     mem_wdata_o <= (idx_q == 2'h0) ? {8'h00, saved_pc_q[23:16]}
                                                     : sr_copy_q;
                  end
               end
            end
            cpu_exception_sequencer_pkg::ST_VEC: begin
               // high word first, then low word of the handler address
               if (mem_done) begin
                  mem_addr_o <= mem_addr_o + 24'h000002;
                  idx_q <= idx_q + 2'h1;
                  if (idx_q == 2'h0) begin
                     pc_o[23:16] <= mem_rdata_i[7:0];
                  end else begin
                     pc_o[15:0] <= mem_rdata_i;
                     mem_req_o <= 1'b0;
                     resume_o <= 1'b1;
                     busy_o <= 1'b0;
                     state_q <= cpu_exception_sequencer_pkg::ST_IDLE;
                  end
               end
            end
            cpu_exception_sequencer_pkg::ST_RSTOUT: begin
               // counted pulse, then the instruction is released as done
               if (rst_cnt_q == 8'h00) begin
                  reset_out_o <= 1'b0;
                  go_o <= 1'b1;
                  busy_o <= 1'b0;
                  state_q <= cpu_exception_sequencer_pkg::ST_IDLE;
               end else begin
                  rst_cnt_q <= rst_cnt_q - 8'h01;
               end
            end
         endcase
      end
   end

   // ***********************************************
   // register bus slave
   // ***********************************************
   // one answer per request, registered one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= 32'h00000000;
         if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
            unique case (wb_adr_i)
               `REG_STATUS_WORD: wb_dat_o <= {16'h0000, sr_q};
               `REG_SSP: wb_dat_o <= {8'h00, ssp_q};
               `REG_HANDLER_PC: wb_dat_o <= {8'h00, pc_o};
               `REG_VECTOR: wb_dat_o <= {24'h000000, vec_q};
               `REG_IRQ_STATE: wb_dat_o <= {27'h0, busy_o, nmi_q, lvl_q};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule

// ---- cpu_exception_sequencer_cfg.svh ----
// offsets, field positions, reset values, encodings and timing counts
`ifndef CPU_EXCEPTION_SEQUENCER_CFG_SVH
`define CPU_EXCEPTION_SEQUENCER_CFG_SVH
// ***********************************************
// register offsets (byte addresses, one word each)
// ***********************************************
`define REG_STATUS_WORD 8'h00
`define REG_SSP 8'h04
`define REG_HANDLER_PC 8'h08
`define REG_VECTOR 8'h0C
`define REG_IRQ_STATE 8'h10
// ***********************************************
// status word fields and reset value
// ***********************************************
`define SR_T 15
`define SR_S 13
`define SR_MASK_HI 10
`define SR_MASK_LO 8
`define SR_RESET 16'h2700
`define LEVEL_TOP 3'h7
// ***********************************************
// function classes on the memory port
// ***********************************************
`define FC_SUP_DATA 3'h5
`define FC_SUP_PROG 3'h6
`define FC_IACK 3'h7
// ***********************************************
// vector numbers
// ***********************************************
`define VEC_RESET 8'h00
`define VEC_ILLEGAL 8'h04
`define VEC_ZERO_DIV 8'h05
`define VEC_BOUNDS 8'h06
`define VEC_OVF_TRAP 8'h07
`define VEC_PRIV 8'h08
`define VEC_LINE_A 8'h0A
`define VEC_LINE_F 8'h0B
`define VEC_SPURIOUS 8'h18
`define VEC_AUTO_BASE 8'h18
`define VEC_TRAP_BASE 8'h20
// ***********************************************
// opcode patterns
// ***********************************************
`define OP_ILL_A 16'h4AFA
`define OP_ILL_B 16'h4AFB
`define OP_ILL_C 16'h4AFC
`define OP_HALT 16'h4E72
`define OP_SW_RESET 16'h4E70
`define OP_EXC_RET 16'h4E73
`define OP_OVF_TRAP 16'h4E76
`define OP_ANDI_SR 16'h027C
`define OP_EORI_SR 16'h0A7C
`define OP_ORI_SR 16'h007C
`define OP_MOVE_SR 16'h46C0
`define MASK_MOVE_SR 16'hFFC0
`define OP_USP_MOVE 16'h4E60
`define OP_TRAP 16'h4E40
`define MASK_LOW4 16'hFFF0
`define OP_BOUNDS 16'h4180
`define OP_UDIV 16'h80C0
`define OP_SDIV 16'h81C0
`define MASK_EA_OP 16'hF1C0
`define LINE_A 4'hA
`define LINE_F 4'hF
// ***********************************************
// timing
// ***********************************************
`define CLK_MHZ 20
`define RST_OUT_NS 6400
`define RST_OUT_CYC ((`RST_OUT_NS * `CLK_MHZ + 999) / 1000)
`endif

// ---- cpu_exception_sequencer_pkg.sv ----
// types shared by the exception sequencer
package cpu_exception_sequencer_pkg;
   typedef enum logic [2:0] {
      ST_BOOT,
      ST_IDLE,
      ST_IACK,
      ST_PUSH,
      ST_VEC,
      ST_RSTOUT
   } seq_state_t;
endpackage

// ---- exc_mem_model.sv ----
// far side model: memory, stack and interrupting device on the memory port
`timescale 1ns/1ps
module exc_mem_model (
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic [2:0] fc_i,
   input wire logic [23:0] addr_i,
   input wire logic slow_i,
   input wire logic avec_en_i,
   input wire logic berr_en_i,
   input wire logic [7:0] vec_i,
   output logic ack_o,
   output logic berr_o,
   output logic avec_o,
   output logic [15:0] rdata_o
);
   logic wait_q;
   logic fin;
   logic iack;
   logic [15:0] d;
   // one wait state per access when slow
   always_ff @(posedge clk_i) wait_q <= req_i && !wait_q && slow_i;
   // every word reads as its address plus 1000h; acknowledge reads give the device vector
   assign iack = fc_i == 3'h7;
   assign fin = req_i && (!slow_i || wait_q);
   assign d = iack ? {8'h00, vec_i} : addr_i[15:0] + 16'h1000;
   assign ack_o = fin && !(iack && berr_en_i);
   assign berr_o = fin && iack && berr_en_i;
   assign avec_o = fin && iack && avec_en_i;
   // idle data is inverted so stale words never pass for fresh ones
   assign rdata_o = ack_o ? d : ~d;
endmodule

// ---- exc_seq_asserts.sv ----
// port checker for the exception sequencer
`timescale 1ns/1ps
// ****************************
// checker
// ****************************
module exc_seq_asserts (
   input logic clk_i,
   input logic reset_i,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_ack_o,
   input logic decode_i,
   input logic done_i,
   input logic mem_ack_i,
   input logic mem_berr_i,
   input logic mem_req_o,
   input logic mem_we_o,
   input logic [2:0] mem_fc_o,
   input logic [23:0] mem_addr_o,
   input logic go_o,
   input logic resume_o,
   input logic busy_o,
   input logic reset_out_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // reset itself is watched, so this one is never disabled
   rst_entry_a: assert property (disable iff (1'b0) reset_i |=> busy_o && mem_req_o
      && !mem_we_o && mem_fc_o == 3'h6 && !go_o) else $error("bad reset state");
   rst_vec_a: assert property (mem_req_o && mem_fc_o == 3'h6 |-> !mem_we_o
      && mem_addr_o[23:3] == 21'h0) else $error("program space read off vector 0");
   wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus not answered");
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   mem_hold_a: assert property (mem_req_o && !mem_ack_i && !mem_berr_i |=> mem_req_o
      && $stable(mem_addr_o) && $stable(mem_we_o)) else $error("memory request moved");
   iack_level_a: assert property (mem_req_o && mem_fc_o == 3'h7 |-> !mem_we_o
      && mem_addr_o[23:4] == 20'hFFFFF && mem_addr_o[0] && mem_addr_o[3:1] != 3'h0)
      else $error("bad acknowledge cycle");
   rstout_only_a: assert property (reset_out_o |-> busy_o && !mem_req_o)
      else $error("memory used during software reset");
   resume_src_a: assert property (resume_o |-> $past(mem_req_o && mem_ack_i && !mem_we_o))
      else $error("resume without vector read");
   decode_ans_a: assert property (decode_i && !done_i && !busy_o |=> go_o != busy_o)
      else $error("decode not answered");
endmodule
bind cpu_exception_sequencer exc_seq_asserts u_chk (.clk_i, .reset_i, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .decode_i, .done_i, .mem_ack_i, .mem_berr_i, .mem_req_o, .mem_we_o, .mem_fc_o,
   .mem_addr_o, .go_o, .resume_o, .busy_o, .reset_out_o);

// ---- testbench.sv ----
// self-checking bench for the exception sequencer
`timescale 1ns/1ps
`include "cpu_exception_sequencer_cfg.svh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("[FAIL] %s exp %h got %h", n, e, a); end end
module testbench;
   logic clk_i, reset_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, decode_i, done_i, wr_seen;
   logic illegal_i, ovf_i, bounds_i, divzero_i, mem_ack_i, mem_berr_i, mem_avec_i, slow;
   logic mem_req_o, mem_we_o, go_o, resume_o, busy_o, reset_out_o, avec_en, berr_en;
   logic [2:0] ipl_i, mem_fc_o;
   logic [7:0] wb_adr_i, iack_vec;
   logic [15:0] opword_i, mem_rdata_i, mem_wdata_o, p;
   logic [23:0] pc_i, next_pc_i, mem_addr_o, pc_o;
   logic [31:0] wb_dat_i, wb_dat_o, w;
   logic [24:0] r;
   logic [24:0] res_q[$];
   logic [15:0] push_q[$];
   logic [31:0] rd_q[$];
   logic [15:0] tr_op[9] = '{16'h4E40, 16'h4E4F, 16'h4E76, 16'h4180, 16'h80C0, 16'h81C0,
      16'h4E76, 16'h4180, 16'h81C0};
   logic [3:0] tr_f[9] = '{4'h0, 4'h0, 4'h4, 4'h2, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0};
   logic [7:0] tr_v[6] = '{8'h20, 8'h2F, 8'h07, 8'h06, 8'h05, 8'h05};
   logic [15:0] dec_op[14] = '{16'h4AFC, 16'h4AFA, 16'h4AFB, 16'hA123, 16'hF00F, 16'h1234,
      16'h4E72, 16'h4E70, 16'h4E73, 16'h46C0, 16'h027C, 16'h0A7C, 16'h007C, 16'h4E60};
   int error_cnt, num_checks, rst_cyc;
   cpu_exception_sequencer u_dut (.clk_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .ipl_i, .decode_i, .done_i, .opword_i,
      .pc_i, .next_pc_i, .illegal_i, .ovf_i, .bounds_i, .divzero_i, .mem_ack_i, .mem_berr_i,
      .mem_avec_i, .mem_rdata_i, .mem_req_o, .mem_we_o, .mem_fc_o, .mem_addr_o, .mem_wdata_o,
      .go_o, .resume_o, .pc_o, .busy_o, .reset_out_o);
   exc_mem_model u_mem (.clk_i, .req_i(mem_req_o), .fc_i(mem_fc_o), .addr_i(mem_addr_o),
      .slow_i(slow), .avec_en_i(avec_en), .berr_en_i(berr_en), .vec_i(iack_vec),
      .ack_o(mem_ack_i), .berr_o(mem_berr_i), .avec_o(mem_avec_i), .rdata_o(mem_rdata_i));
   // ****************************
   // helpers
   // ****************************
   // handler address as the memory model lays out vector v
   function automatic logic [23:0] vpc(input logic [7:0] v);
      logic [15:0] a;
      a = {6'h00, v, 2'h0} + 16'h1000;
      return {a[7:0], a + 16'h0002};
   endfunction
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      if (!we) rd_q.push_back(d);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 9);
      if (n >= 9) begin error_cnt++; end_of_test(); end
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      @(posedge clk_i);
   endtask
   // any nonzero k waits for go or resume; k=0 just idles so stray answers show up
   task automatic wt(input int k);
      int n;
      n = 0;
      rst_cyc = 0;
      while (k != 0 && go_o !== 1'b1 && resume_o !== 1'b1 && n < 400) begin
         @(posedge clk_i);
         n++;
         rst_cyc += reset_out_o;
      end
      if (n >= 400) begin error_cnt++; end_of_test(); end
      repeat (3) @(posedge clk_i);
   endtask
   task automatic ev(input logic dn, input logic [15:0] op, input logic [3:0] f, input int k,
         input logic [7:0] v);
      logic [23:0] a;
      a = 24'($urandom) & 24'hFFFFFE;
      slow <= 1'($urandom);
      if (k == 1) res_q.push_back({1'b0, 24'h0});
      if (k == 2) res_q.push_back({1'b1, vpc(v)});
      if (k == 2) push_q.push_back(dn ? a[15:0] + 16'h0002 : a[15:0]);
      decode_i <= !dn;
      done_i <= dn;
      opword_i <= op;
      pc_i <= a;
      next_pc_i <= a + 24'h2;
      {illegal_i, ovf_i, bounds_i, divzero_i} <= f;
      @(posedge clk_i);
      decode_i <= 0;
      done_i <= 0;
      {illegal_i, ovf_i, bounds_i, divzero_i} <= 4'h0;
      wt(k);
   endtask
   task automatic irq(input logic [2:0] l, input logic [1:0] m);
      ipl_i <= l;
      {avec_en, berr_en} <= m;
      repeat (5) @(posedge clk_i);
   endtask
   // ****************************
   // result watcher
   // ****************************
   always @(posedge clk_i) begin
      if (go_o === 1'b1 || resume_o === 1'b1) begin
         r = res_q.size() ? res_q.pop_front() : 'x;
         `CHK("answer_kind", r[24], resume_o)
         if (resume_o === 1'b1) `CHK("handler_pc", r[23:0], pc_o)
      end
      // first write of each sequence is the saved counter, low word
      if (mem_req_o === 1'b1 && mem_we_o && mem_ack_i && !wr_seen) begin
         p = push_q.size() ? push_q.pop_front() : 'x;
         `CHK("saved_pc", p, mem_wdata_o)
         wr_seen = 1;
      end
      if (resume_o === 1'b1) wr_seen = 0;
      if (wb_ack_o === 1'b1 && !wb_we_i) begin
         w = rd_q.size() ? rd_q.pop_front() : 'x;
         `CHK("reg_read", w, wb_dat_o)
      end
   end
   initial begin
      clk_i = 0;
      forever #25 clk_i = ~clk_i;
   end
   // ****************************
   // main sequence
   // ****************************
   initial begin
      reset_i = 1;
      {wb_cyc_i, wb_stb_i, wb_we_i, decode_i, done_i, slow, avec_en, berr_en} = 8'h00;
      {illegal_i, ovf_i, bounds_i, divzero_i, ipl_i, wb_adr_i, opword_i} = 31'h0;
      {pc_i, next_pc_i, wb_dat_i, wr_seen} = 81'h0;
      iack_vec = 8'h40;
      void'($urandom(32'h4081BF6E));
      res_q.push_back({1'b1, vpc(8'h01)}); // start address sits in the slot of vector 1, after the stack pointer
      repeat (8) @(posedge clk_i);
      reset_i <= 0;
      wt(1);
      wb(0, `REG_STATUS_WORD, 32'h00002700);
      wb(0, `REG_SSP, 32'h00001002);
      wb(0, 8'h20, 32'h0);
      $display("test reset done");
      foreach (dec_op[i]) begin
         wb(1, `REG_STATUS_WORD, 32'h0);
         ev(0, dec_op[i], {i == 5, 3'h0}, 2, i == 3 ? `VEC_LINE_A : i == 4 ? `VEC_LINE_F :
            i < 6 ? `VEC_ILLEGAL : `VEC_PRIV);
      end
      wb(1, `REG_STATUS_WORD, 32'h00002000);
      ev(0, `OP_EXC_RET, 4'h0, 1, 8'h0);
      $display("test decode exceptions done");
      foreach (tr_op[i]) begin
         ev(0, tr_op[i], 4'h0, 1, 8'h0);
         ev(1, tr_op[i], tr_f[i], i < 6 ? 2 : 0, tr_v[i % 6]);
      end
      $display("test traps done");
      wb(1, `REG_STATUS_WORD, 32'h0000A300);
      irq(3'h3, 2'h2);
      ev(0, 16'h4E71, 4'h0, 1, 8'h0);
      irq(3'h4, 2'h2);
      ev(0, `OP_ILL_C, 4'h0, 2, 8'h1C);
      wb(0, `REG_STATUS_WORD, 32'h00002400);
      wb(1, `REG_STATUS_WORD, 32'h00002000);
      irq(3'h2, 2'h1);
      ev(0, 16'h4E71, 4'h0, 2, `VEC_SPURIOUS);
      irq(3'h6, 2'h0);
      ev(0, 16'h4E71, 4'h0, 2, 8'h40);
      wb(1, `REG_STATUS_WORD, 32'h00002700);
      irq(3'h0, 2'h2);
      irq(3'h7, 2'h2);
      ev(0, 16'h4E71, 4'h0, 2, 8'h1F);
      ev(0, 16'h4E71, 4'h0, 1, 8'h0);
      wb(1, `REG_STATUS_WORD, 32'h00002600);
      ev(0, 16'h4E71, 4'h0, 2, 8'h1F);
      $display("test interrupts done");
      ev(0, `OP_SW_RESET, 4'h0, 1, 8'h0);
      `CHK("reset_out_len", `RST_OUT_CYC, rst_cyc)
      $display("test software reset done");
      end_of_test();
   end
endmodule
